// *** dhc_consts.svh ***
`ifndef DHC_CONSTS_SVH
`define DHC_CONSTS_SVH
`define DHC_AW 24
`define DHC_CW 12
`define DHC_REG_CTRL 3'h0
`define DHC_REG_HEXT 3'h1
`define DHC_REG_BLO 3'h2
`define DHC_REG_BHI 3'h3
`define DHC_REG_XLO 3'h4
`define DHC_REG_XHI 3'h5
`define DHC_REG_YLO 3'h6
`define DHC_REG_YHI 3'h7
`define DHC_ADDR_CFG0 8'h10
`define DHC_ADDR_PIDX 8'h11
`define DHC_ADDR_PDATA 8'h12
`define DHC_ADDR_STAT 8'h13
`define DHC_CUR_SPACE 4'h0
`define DHC_CFG0_ALT 0
`define DHC_CTL_VEXT 3
`define DHC_CTL_HSTR 4
`define DHC_CTL_VSTR 5
`define DHC_CTL_BLINK 6
`define DHC_CTL_ORG 7
`define DHC_M_OFF 3'h0
`define DHC_M_AX32 3'h1
`define DHC_M_AX64 3'h2
`define DHC_M_C4 3'h3
`define DHC_M_C3T 3'h4
`define DHC_M_C2 3'h5
`define DHC_M_C1T 3'h6
`define DHC_W32 8'h20
`define DHC_W64 8'h40
`define DHC_W128 8'h80
`define DHC_BLINK_FRAMES 5'h10
`define DHC_LAST_WORD 3'h7
`define DHC_LAST_BYTE 2'h2
`define DHC_GROUP_BYTES 12'h010
`define DHC_WORD_BYTES 12'h004
`define DHC_REGION_LSB 12
`endif

// *** dhc_pkg.sv ***
package dhc_pkg;
   typedef logic [23:0] dhc_rgb_type;
   typedef logic [7:0] dhc_byte_type;
   typedef enum logic {DHC_FS_IDLE, DHC_FS_REQ} dhc_fetch_state_type;
endpackage

// *** dhc_link_if.sv ***
interface dhc_link_if;
   import dhc_pkg::*;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_addr;
   dhc_byte_type reg_wdata;
   dhc_byte_type reg_rdata;
   logic line_start;
   logic vsync;
   logic pix_valid;
   logic [11:0] x;
   logic [11:0] y;
   dhc_rgb_type main_pix;
   logic h_dup;
   logic v_dup;
   logic panel;
   logic border_en;
   logic [11:0] border_left;
   logic [11:0] border_top;
   logic fetch_req;
   logic [23:0] fetch_addr;
   logic fetch_ack;
   logic [31:0] fetch_data;
   logic out_valid;
   dhc_rgb_type out_pix;
   dhc_rgb_type border_crt;
   dhc_rgb_type border_panel;
   modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata, line_start, vsync, pix_valid, x, y, main_pix,
      h_dup, v_dup, panel, border_en, border_left, border_top, fetch_ack, fetch_data,
      output reg_rdata, fetch_req, fetch_addr, out_valid, out_pix, border_crt, border_panel);
   modport host (output reg_wr, reg_rd, reg_addr, reg_wdata, line_start, vsync, pix_valid, x, y, main_pix,
      h_dup, v_dup, panel, border_en, border_left, border_top, fetch_ack, fetch_data,
      input reg_rdata, fetch_req, fetch_addr, out_valid, out_pix, border_crt, border_panel);
endinterface

// *** dhc_overlay.sv ***
// How it works
// - Two cursors: pointer first, overlay second.
// - Eight registers per cursor.
// - Four registers give X and Y position.
// - Pattern fetched from off-screen memory, selectable.
// - Alternate entries 4-7 cursor one, 0-3 two.
// - Select bit routes palette writes to alternates.
// - Each cursor disabled or one of six modes.
// - Stretching per cursor, flat panel only.
// - Stretch follows main stretcher, own enable.
// - Control bit turns blinking on or off.
// - Control bit picks active or border origin.
// - Vertical extension allows non-square cursors.
// - Base is frame buffer offset from two registers.
// - Each cursor owns a 4KB data region.
// - Top four base-low bits select pattern.
// - 32x32 mode: sixteen 256-byte patterns.
// - 64x64 modes: four 1KB patterns, top bits.
// - 128x128 modes: two 2KB patterns, top bit.
// - Control bit 3 enables height register.
// - Control bits 2-0 encode off or mode.
// - Border on: entries 6,7 give border colours.
//
// The strobed register port and the address map are this design's own decisions.
`include "dhc_consts.svh"
module dhc_overlay (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   dhc_link_if.dev lnk
);
   import dhc_pkg::*;

   dhc_byte_type creg_r [0:1][0:7];
   dhc_byte_type cfg0_r;
   dhc_byte_type rdata_r;
   dhc_rgb_type pal_r [0:7];
   logic [2:0] pidx_r;
   logic [1:0] pbyte_r;
   logic [4:0] bcnt_r;
   logic blink_on_r;
   logic [31:0] lbuf_r [0:7];
   logic [7:0] row_r [0:1];
   logic vstart_r [0:1];
   logic [7:0] col_r [0:1];
   logic hstart_r [0:1];
   logic [7:0] col_now [0:1];
   logic hit_now [0:1];
   dhc_fetch_state_type fst_r;
   logic [2:0] fk_r;
   logic ls_d_r;
   logic freq_r;
   logic [23:0] faddr_r;
   logic ov_r;
   dhc_rgb_type opix_r;
   logic [24:0] c1_pix;
   logic [24:0] c2_pix;

   function automatic logic [7:0] mode_width(input logic [2:0] mode);
      unique case (mode)
         `DHC_M_AX32: mode_width = `DHC_W32;
         `DHC_M_AX64, `DHC_M_C4, `DHC_M_C3T: mode_width = `DHC_W64;
         `DHC_M_C2, `DHC_M_C1T: mode_width = `DHC_W128;
         default: mode_width = 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] cur_height(input logic c);
      if (creg_r[c][`DHC_REG_CTRL][`DHC_CTL_VEXT]) begin
         cur_height = creg_r[c][`DHC_REG_HEXT];
      end else begin
         cur_height = mode_width(creg_r[c][`DHC_REG_CTRL][2:0]);
      end
   endfunction

   function automatic logic [11:0] pos(input logic c, input logic [2:0] lo, input logic [11:0] edge_off);
      logic [11:0] p;
      p = {creg_r[c][lo + 3'h1][3:0], creg_r[c][lo]};
      pos = creg_r[c][`DHC_REG_CTRL][`DHC_CTL_ORG] ? p : 12'(p + edge_off);
   endfunction

   // Fetch address for word k: cursor index ~k[2], word k[1:0] of the current 16-byte line group.
   function automatic logic [23:0] fetch_addr(input logic [2:0] k);
      logic c;
      logic [2:0] mode;
      logic [3:0] sel;
      logic [11:0] pat;
      logic [7:0] grp;
      c = ~k[2];
      mode = creg_r[c][`DHC_REG_CTRL][2:0];
      sel = creg_r[c][`DHC_REG_BLO][7:4];
      grp = (mode == `DHC_M_AX32) ? {1'b0, row_r[c][7:1]} : row_r[c];
      unique case (mode)
         `DHC_M_AX32: pat = {sel, 8'h00};
         `DHC_M_C2, `DHC_M_C1T: pat = {sel[3], 11'h000};
         default: pat = {sel[3:2], 10'h000};
      endcase
      // The sum wraps inside 12 bits so an over-tall cursor never leaves its region.
      fetch_addr = {creg_r[c][`DHC_REG_BHI], creg_r[c][`DHC_REG_BLO][3:0],
         12'(pat + 12'(grp * `DHC_GROUP_BYTES) + 12'(k[1:0] * `DHC_WORD_BYTES))};
   endfunction

   function automatic logic [1:0] pix_code(input logic c, input logic [7:0] col);
      logic [127:0] ln;
      ln = {lbuf_r[{~c, 2'h3}], lbuf_r[{~c, 2'h2}], lbuf_r[{~c, 2'h1}], lbuf_r[{~c, 2'h0}]};
      unique case (creg_r[c][`DHC_REG_CTRL][2:0])
         `DHC_M_AX32: pix_code = {ln[{1'b0, row_r[c][0], col[4:0]}], ln[{1'b1, row_r[c][0], col[4:0]}]};
         `DHC_M_AX64: pix_code = {ln[{1'b0, col[5:0]}], ln[{1'b1, col[5:0]}]};
         `DHC_M_C4, `DHC_M_C3T: pix_code = {ln[{col[5:0], 1'b1}], ln[{col[5:0], 1'b0}]};
         default: pix_code = {1'b0, ln[col[6:0]]};
      endcase
   endfunction

   // Bit 24 is the show flag, bits 23:0 the colour.
   function automatic logic [24:0] cur_colour(input logic c, input logic [1:0] code, input dhc_rgb_type main);
      logic [2:0] idx;
      logic show;
      logic inv;
      idx = {~c, code};
      show = 1'b1;
      inv = 1'b0;
      unique case (creg_r[c][`DHC_REG_CTRL][2:0])
         `DHC_M_AX32, `DHC_M_AX64: begin
            show = ~code[1];
            inv = (code == 2'h3);
            idx = {~c, 1'b0, code[0]};
         end
         `DHC_M_C4: show = 1'b1;
         `DHC_M_C3T: show = (code != 2'h3);
         `DHC_M_C2: idx = {~c, 1'b0, code[0]};
         `DHC_M_C1T: begin
            show = code[0];
            idx = {~c, 2'h0};
         end
         default: show = 1'b0;
      endcase
      if (c == 1'b0 && lnk.border_en && idx[1]) begin
         show = 1'b0;
      end
      cur_colour = {show | inv, inv ? ~main : pal_r[idx]};
   endfunction

   // Register writes and read-back.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int c = 0; c < 2; c++) begin
            for (int r = 0; r < 8; r++) begin
               creg_r[c][r] <= 8'h00;
            end
         end
         cfg0_r <= 8'h00;
      end else if (lnk.reg_wr) begin
         if (lnk.reg_addr[7:4] == `DHC_CUR_SPACE) begin
            creg_r[lnk.reg_addr[3]][lnk.reg_addr[2:0]] <= lnk.reg_wdata;
         end else if (lnk.reg_addr == `DHC_ADDR_CFG0) begin
            cfg0_r <= lnk.reg_wdata;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_r <= 8'h00;
      end else if (lnk.reg_rd) begin
         if (lnk.reg_addr[7:4] == `DHC_CUR_SPACE) begin
            rdata_r <= creg_r[lnk.reg_addr[3]][lnk.reg_addr[2:0]];
         end else if (lnk.reg_addr == `DHC_ADDR_CFG0) begin
            rdata_r <= cfg0_r;
         end else if (lnk.reg_addr == `DHC_ADDR_PIDX) begin
            rdata_r <= {3'h0, pbyte_r, pidx_r};
         end else if (lnk.reg_addr == `DHC_ADDR_STAT) begin
            rdata_r <= {4'h0, fst_r == DHC_FS_REQ, blink_on_r, hit_now[1], hit_now[0]};
         end else begin
            rdata_r <= 8'h00;
         end
      end
   end

   // Palette data writes reach the alternates only while the select bit is set.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pidx_r <= 3'h0;
         pbyte_r <= 2'h0;
         for (int i = 0; i < 8; i++) begin
            pal_r[i] <= 24'h00_0000;
         end
      end else if (lnk.reg_wr && lnk.reg_addr == `DHC_ADDR_PIDX) begin
         pidx_r <= lnk.reg_wdata[2:0];
         pbyte_r <= 2'h0;
      end else if (lnk.reg_wr && lnk.reg_addr == `DHC_ADDR_PDATA && cfg0_r[`DHC_CFG0_ALT]) begin
         pal_r[pidx_r][{`DHC_LAST_BYTE - pbyte_r, 3'h0} +: 8] <= lnk.reg_wdata;
         pbyte_r <= (pbyte_r == `DHC_LAST_BYTE) ? 2'h0 : 2'(pbyte_r + 2'h1);
         pidx_r <= (pbyte_r == `DHC_LAST_BYTE) ? 3'(pidx_r + 3'h1) : pidx_r;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bcnt_r <= 5'h00;
         blink_on_r <= 1'b1;
      end else if (lnk.vsync) begin
         bcnt_r <= (bcnt_r == 5'(`DHC_BLINK_FRAMES - 5'h01)) ? 5'h00 : 5'(bcnt_r + 5'h01);
         blink_on_r <= (bcnt_r == 5'(`DHC_BLINK_FRAMES - 5'h01)) ? ~blink_on_r : blink_on_r;
      end
   end

   // Row and column tracking, one copy per cursor.
   for (genvar c = 0; c < 2; c++) begin : g_cur
      logic vs;
      logic hs;
      assign vs = lnk.panel && creg_r[c][`DHC_REG_CTRL][`DHC_CTL_VSTR];
      assign hs = lnk.panel && creg_r[c][`DHC_REG_CTRL][`DHC_CTL_HSTR];
      assign col_now[c] = !hstart_r[c] ? 8'h00 : (hs && lnk.h_dup) ? col_r[c] : 8'(col_r[c] + 8'h01);
      always_comb hit_now[c] = (creg_r[c][`DHC_REG_CTRL][2:0] != `DHC_M_OFF) && vstart_r[c]
         && (row_r[c] < cur_height(c)) && (hstart_r[c] || lnk.x >= pos(c, `DHC_REG_XLO, lnk.border_left))
         && (col_now[c] < mode_width(creg_r[c][`DHC_REG_CTRL][2:0]));

      always_ff @(posedge i_mclk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            row_r[c] <= 8'h00;
            vstart_r[c] <= 1'b0;
         end else if (lnk.vsync) begin
            row_r[c] <= 8'h00;
            vstart_r[c] <= 1'b0;
         end else if (lnk.line_start) begin
            if (!vstart_r[c] && lnk.y >= pos(c, `DHC_REG_YLO, lnk.border_top)) begin
               vstart_r[c] <= 1'b1;
            end else if (vstart_r[c] && !(vs && lnk.v_dup) && row_r[c] != 8'hFF) begin
               row_r[c] <= 8'(row_r[c] + 8'h01);
            end
         end
      end

      always_ff @(posedge i_mclk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            col_r[c] <= 8'h00;
            hstart_r[c] <= 1'b0;
         end else if (lnk.line_start) begin
            col_r[c] <= 8'h00;
            hstart_r[c] <= 1'b0;
         end else if (lnk.pix_valid && (hstart_r[c] || lnk.x >= pos(c, `DHC_REG_XLO, lnk.border_left))) begin
            hstart_r[c] <= 1'b1;
            col_r[c] <= (col_now[c] == 8'hFF) ? col_r[c] : col_now[c];
         end
      end
   end

   // Line fetch: eight words per line in blanking; it must finish before the active pixels start.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ls_d_r <= 1'b0;
      end else begin
         ls_d_r <= lnk.line_start;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fst_r <= DHC_FS_IDLE;
         fk_r <= 3'h0;
         freq_r <= 1'b0;
         faddr_r <= 24'h00_0000;
      end else if (ls_d_r) begin
         fst_r <= DHC_FS_REQ;
         fk_r <= 3'h0;
         freq_r <= 1'b1;
         faddr_r <= fetch_addr(3'h0);
      end else begin
         unique case (fst_r)
            DHC_FS_IDLE: freq_r <= 1'b0;
            DHC_FS_REQ: if (lnk.fetch_ack) begin
               fk_r <= 3'(fk_r + 3'h1);
               faddr_r <= fetch_addr(3'(fk_r + 3'h1));
               if (fk_r == `DHC_LAST_WORD) begin
                  fst_r <= DHC_FS_IDLE;
                  freq_r <= 1'b0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < 8; i++) begin
            lbuf_r[i] <= 32'h0000_0000;
         end
      end else if (fst_r == DHC_FS_REQ && lnk.fetch_ack) begin
         lbuf_r[fk_r] <= lnk.fetch_data;
      end
   end

   // The pointer cursor sits above the overlay cursor.
   // A process rather than an assign, so that palette and register changes seen inside the functions re-evaluate it.
   always_comb c1_pix = cur_colour(1'b0, pix_code(1'b0, col_now[0]), lnk.main_pix);
   always_comb c2_pix = cur_colour(1'b1, pix_code(1'b1, col_now[1]), lnk.main_pix);

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ov_r <= 1'b0;
         opix_r <= 24'h00_0000;
      end else begin
         ov_r <= lnk.pix_valid;
         if (hit_now[0] && c1_pix[24] && (blink_on_r || !creg_r[0][`DHC_REG_CTRL][`DHC_CTL_BLINK])) begin
            opix_r <= c1_pix[23:0];
         end else if (hit_now[1] && c2_pix[24] && (blink_on_r || !creg_r[1][`DHC_REG_CTRL][`DHC_CTL_BLINK])) begin
            opix_r <= c2_pix[23:0];
         end else begin
            opix_r <= lnk.main_pix;
         end
      end
   end

   assign lnk.reg_rdata = rdata_r;
   assign lnk.fetch_req = freq_r;
   assign lnk.fetch_addr = faddr_r;
   assign lnk.out_valid = ov_r;
   assign lnk.out_pix = opix_r;
   assign lnk.border_crt = pal_r[6];
   assign lnk.border_panel = pal_r[7];
endmodule

// *** dhc_pipe_end.sv ***
`include "dhc_consts.svh"
module dhc_pipe_end (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   output logic o_height_missing,
   input wire logic i_line_start,
   input wire logic i_vsync,
   input wire logic i_pix_valid,
   input wire logic [11:0] i_x,
   input wire logic [11:0] i_y,
   input wire dhc_pkg::dhc_rgb_type i_main_pix,
   input wire logic i_h_dup,
   input wire logic i_v_dup,
   input wire logic i_panel,
   input wire logic i_border_en,
   input wire logic [11:0] i_border_left,
   input wire logic [11:0] i_border_top,
   output logic o_mem_rd,
   output logic [23:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_data,
   output logic o_pix_valid,
   output dhc_pkg::dhc_rgb_type o_pix,
   output dhc_pkg::dhc_rgb_type o_border_crt,
   output dhc_pkg::dhc_rgb_type o_border_panel,
   dhc_link_if.host lnk
);
   import dhc_pkg::*;

   logic [2:0] mode_r [0:1];
   logic hset_r [0:1];
   logic vext_r [0:1];
   logic [7:0] wdata_fix;
   logic cur_wr;

   assign cur_wr = i_wr && i_addr[7:4] == `DHC_CUR_SPACE;

   // Shadow of each cursor's mode, used to clean pattern-select writes, and of its height state for o_height_missing.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int c = 0; c < 2; c++) begin
            mode_r[c] <= `DHC_M_OFF;
            hset_r[c] <= 1'b0;
            vext_r[c] <= 1'b0;
         end
      end else if (cur_wr && i_addr[2:0] == `DHC_REG_CTRL) begin
         mode_r[i_addr[3]] <= i_wdata[2:0];
         vext_r[i_addr[3]] <= i_wdata[`DHC_CTL_VEXT];
      end else if (cur_wr && i_addr[2:0] == `DHC_REG_HEXT) begin
         hset_r[i_addr[3]] <= 1'b1;
      end
   end

   always_comb begin
      wdata_fix = i_wdata;
      if (cur_wr && i_addr[2:0] == `DHC_REG_BLO) begin
         unique case (mode_r[i_addr[3]])
            `DHC_M_AX64, `DHC_M_C4, `DHC_M_C3T: wdata_fix[5:4] = 2'h0;
            `DHC_M_C2, `DHC_M_C1T: wdata_fix[6:4] = 3'h0;
            default: wdata_fix = i_wdata;
         endcase
      end
   end

   assign o_height_missing = (vext_r[0] && !hset_r[0]) || (vext_r[1] && !hset_r[1]);
   // Software sets the select bit through this same port before writing alternate colours.
   assign lnk.reg_wr = i_wr;
   assign lnk.reg_rd = i_rd;
   assign lnk.reg_addr = i_addr;
   assign lnk.reg_wdata = wdata_fix;
   assign o_rdata = lnk.reg_rdata;
   assign lnk.line_start = i_line_start;
   assign lnk.vsync = i_vsync;
   assign lnk.pix_valid = i_pix_valid;
   assign lnk.x = i_x;
   assign lnk.y = i_y;
   assign lnk.main_pix = i_main_pix;
   assign lnk.h_dup = i_h_dup;
   assign lnk.v_dup = i_v_dup;
   assign lnk.panel = i_panel;
   assign lnk.border_en = i_border_en;
   assign lnk.border_left = i_border_left;
   assign lnk.border_top = i_border_top;
   assign o_mem_rd = lnk.fetch_req;
   assign o_mem_addr = lnk.fetch_addr;
   assign lnk.fetch_ack = i_mem_ack;
   assign lnk.fetch_data = i_mem_data;
   assign o_pix_valid = lnk.out_valid;
   assign o_pix = lnk.out_pix;
   assign o_border_crt = lnk.border_crt;
   assign o_border_panel = lnk.border_panel;
endmodule

// *** dhc_link_properties.sv ***
module dhc_link_properties (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire dhc_pkg::dhc_byte_type reg_wdata,
   input wire dhc_pkg::dhc_byte_type reg_rdata,
   input wire logic line_start,
   input wire logic pix_valid,
   input wire dhc_pkg::dhc_rgb_type main_pix,
   input wire logic fetch_req,
   input wire logic [23:0] fetch_addr,
   input wire logic fetch_ack,
   input wire logic out_valid,
   input wire dhc_pkg::dhc_rgb_type out_pix
);
   timeunit 1ns;
   timeprecision 1ns;
   import dhc_pkg::*;
   logic [7:0] shadow_r [16];
   logic [7:0] shadow_sel;
   logic [3:0] acks_r;
   // Position high bytes read back whole, although only their low four bits place the cursor.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int k = 0; k < 16; k++) shadow_r[k] <= 8'h00;
      end else if (reg_wr && reg_addr < 8'h10) begin
         shadow_r[reg_addr[3:0]] <= reg_wdata;
      end
   end
   assign shadow_sel = shadow_r[reg_addr[3:0]];
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         acks_r <= 4'h0;
      end else if (line_start) begin
         acks_r <= 4'h0;
      end else if (fetch_req && fetch_ack) begin
         acks_r <= acks_r + 4'h1;
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   pix_delay_a: assert property (out_valid == $past(pix_valid))
      else $error("output pixel valid does not follow input by one cycle");
   fetch_start_a: assert property (line_start |-> ##2 fetch_req)
      else $error("fetch not raised two edges after line start");
   addr_hold_a: assert property (fetch_req && !fetch_ack && !line_start && !$past(line_start) |=> $stable(fetch_addr))
      else $error("fetch address moved without an acknowledge");
   addr_step_a: assert property (fetch_req && fetch_ack && fetch_addr[3:2] != 2'h3 && !line_start
      && !$past(line_start) |=> fetch_addr == $past(fetch_addr) + 24'h00_0004)
      else $error("fetch address did not step by one word");
   fetch_end_a: assert property (acks_r == 4'h8 && !line_start |-> !fetch_req)
      else $error("fetch request still high after eight words");
   unmapped_zero_a: assert property (reg_rd && (reg_addr > 8'h13 || reg_addr == 8'h12) |=> reg_rdata == 8'h00)
      else $error("unmapped or write-only read gave nonzero data");
   cursor_readback_a: assert property (reg_rd && reg_addr < 8'h10 |=> reg_rdata == $past(shadow_sel))
      else $error("cursor register read back differs from last write");
   off_passthru_a: assert property (pix_valid && shadow_r[0][2:0] == 3'h0 && shadow_r[8][2:0] == 3'h0
      |=> out_pix == $past(main_pix))
      else $error("main pixel altered while both cursors are off");
   cover property (fetch_req && fetch_ack);
   cover property (acks_r == 4'h8);
   cover property (reg_rd && reg_addr == 8'h11);
endmodule

// *** tb.sv ***
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import dhc_pkg::*;
   localparam dhc_rgb_type main_c = 24'h80_40C0;
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0, i_rd = 1'b0, i_line_start = 1'b0, i_vsync = 1'b0, i_pix_valid = 1'b0, i_mem_ack = 1'b0;
   logic [11:0] i_x = 12'h000, i_y = 12'h000, bdr_l = 12'h004, bdr_t = 12'h002;
   dhc_rgb_type i_main_pix = 24'h00_0000;
   logic [31:0] i_mem_data = 32'h0000_0000;
   logic [7:0] o_rdata;
   logic o_height_missing, o_mem_rd, o_pix_valid;
   logic [23:0] o_mem_addr;
   dhc_rgb_type o_pix, o_border_crt, o_border_panel;
   int mismatches = 0, checks_done = 0;
   dhc_rgb_type pal [4] = '{24'h11_2233, 24'h44_5566, 24'h77_8899, 24'hAA_BBCC};
   // Words 0-3 of a line belong to the overlay cursor, words 4-7 to the pointer cursor.
   logic [31:0] words [8] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
      32'h0000_000A, 32'h0000_0000, 32'h0000_000C, 32'h0000_0000};
   logic [7:0] cur_cfg [8] = '{8'h01, 8'h20, 8'h21, 8'h05, 8'h06, 8'h00, 8'h00, 8'h00};
   always #50 i_mclk = ~i_mclk;
   dhc_link_if lnk_w ();
   dhc_overlay dhc_overlay_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .lnk(lnk_w));
   dhc_pipe_end dhc_pipe_end_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_height_missing(o_height_missing),
      .i_line_start(i_line_start), .i_vsync(i_vsync), .i_pix_valid(i_pix_valid), .i_x(i_x), .i_y(i_y),
      .i_main_pix(i_main_pix), .i_h_dup(1'b0), .i_v_dup(1'b0), .i_panel(1'b0), .i_border_en(1'b0),
      .i_border_left(bdr_l), .i_border_top(bdr_t), .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr),
      .i_mem_ack(i_mem_ack), .i_mem_data(i_mem_data), .o_pix_valid(o_pix_valid), .o_pix(o_pix),
      .o_border_crt(o_border_crt), .o_border_panel(o_border_panel), .lnk(lnk_w));
   dhc_link_properties dhc_link_properties_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .reg_wr(lnk_w.reg_wr),
      .reg_rd(lnk_w.reg_rd), .reg_addr(lnk_w.reg_addr), .reg_wdata(lnk_w.reg_wdata),
      .reg_rdata(lnk_w.reg_rdata), .line_start(lnk_w.line_start), .pix_valid(lnk_w.pix_valid),
      .main_pix(lnk_w.main_pix), .fetch_req(lnk_w.fetch_req), .fetch_addr(lnk_w.fetch_addr),
      .fetch_ack(lnk_w.fetch_ack), .out_valid(lnk_w.out_valid), .out_pix(lnk_w.out_pix));
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   // Read data appear in the cycle after the strobe and hold until the next read; they are taken at that cycle's falling edge.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      @(negedge i_mclk);
      chk_reg(o_rdata, exp);
   endtask
   task automatic t_height;
      wr(8'h00, 8'h09);
      @(negedge i_mclk);
      chk_val({23'h00_0000, o_height_missing}, 24'h00_0001);
      wr(8'h01, 8'h20);
      @(negedge i_mclk);
      chk_val({23'h00_0000, o_height_missing}, 24'h00_0000);
   endtask
   task automatic t_regs;
      logic [7:0] v;
      for (int a = 0; a < 16; a++) wr(8'(a), 8'h30 + 8'(a));
      for (int a = 0; a < 16; a++) begin
         v = 8'h30 + 8'(a);
         rd(8'(a), v);
      end
      rd(8'h20, 8'h00);
      rd(8'h12, 8'h00);
      rd(8'h13, 8'h04);
      repeat (16) begin
         @(posedge i_mclk);
         i_vsync <= 1'b1;
         @(posedge i_mclk);
         i_vsync <= 1'b0;
      end
      rd(8'h13, 8'h00);
   endtask
   task automatic t_mask;
      for (int m = 1; m < 7; m++) begin
         wr(8'h00, 8'(m));
         wr(8'h02, 8'hF3);
         rd(8'h02, m >= 5 ? 8'h83 : (m >= 2 ? 8'hC3 : 8'hF3));
      end
   endtask
   task automatic t_palette;
      wr(8'h10, 8'h01);
      wr(8'h11, 8'h04);
      for (int e = 0; e < 4; e++) begin
         for (int b = 0; b < 3; b++) begin
            wr(8'h12, pal[e][23 - 8 * b -: 8]);
            if (e == 0 && b != 1) rd(8'h11, b == 0 ? 8'h0C : 8'h05);
         end
      end
      @(negedge i_mclk);
      chk_val(o_border_crt, pal[2]);
      chk_val(o_border_panel, pal[3]);
      wr(8'h10, 8'h00);
      wr(8'h11, 8'h06);
      repeat (3) wr(8'h12, 8'hFF);
      @(negedge i_mclk);
      chk_val(o_border_crt, pal[2]);
   endtask
   // The fetch answer is slowed on some words so the request must hold its address across wait cycles.
   task automatic t_fetch;
      int n;
      for (int a = 0; a < 8; a++) wr(8'(a), cur_cfg[a]);
      wr(8'h08, 8'h00);
      @(posedge i_mclk);
      i_vsync <= 1'b1;
      @(posedge i_mclk);
      i_vsync <= 1'b0;
      i_line_start <= 1'b1;
      i_y <= 12'h002;
      @(posedge i_mclk);
      i_line_start <= 1'b0;
      for (int w = 0; w < 8; w++) begin
         n = 0;
         @(negedge i_mclk);
         while (o_mem_rd !== 1'b1 && n < 20) begin
            n++;
            @(negedge i_mclk);
         end
         chk_val({23'h00_0000, o_mem_rd}, 24'h00_0001);
         chk_val(o_mem_addr, (w < 4 ? 24'h3B_A000 : 24'h05_1200) + 24'(4 * (w % 4)));
         repeat (w % 3) @(posedge i_mclk);
         @(posedge i_mclk);
         i_mem_ack <= 1'b1;
         i_mem_data <= words[w];
         @(posedge i_mclk);
         i_mem_ack <= 1'b0;
      end
      @(negedge i_mclk);
      chk_val({23'h00_0000, o_mem_rd}, 24'h00_0000);
   endtask
   task automatic t_pixels(input logic on);
      dhc_rgb_type ex [7];
      ex = '{main_c, main_c, pal[0], main_c, pal[1], ~main_c, pal[0]};
      for (int k = 0; k < 8; k++) begin
         @(posedge i_mclk);
         i_pix_valid <= (k < 7);
         i_x <= 12'h008 + 12'(k);
         i_main_pix <= main_c;
         @(negedge i_mclk);
         if (k > 0) chk_val(o_pix, on ? ex[k - 1] : main_c);
      end
      @(posedge i_mclk);
      i_pix_valid <= 1'b0;
   endtask
   task automatic print_verdict;
      $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge i_mclk);
      mismatches++;
      print_verdict();
   end
   initial begin
      repeat (9) @(posedge i_mclk);
      @(negedge i_mclk);
      chk_val({o_rdata, 14'h0000, o_mem_rd, o_pix_valid}, 24'h00_0000);
      chk_val(o_pix, 24'h00_0000);
      @(posedge i_mclk);
      i_rst_n <= 1'b1;
      t_height();
      t_regs();
      t_mask();
      t_palette();
      t_fetch();
      t_pixels(1'b1);
      wr(8'h00, 8'h00);
      t_pixels(1'b0);
      print_verdict();
   end
endmodule
